/* File: rtl/sacc_defines.vh */
// register map, field positions and sequencer codes for the signal accelerator
`ifndef SACC_DEFINES_VH
`define SACC_DEFINES_VH
`define SACC_AW          17
`define SACC_A_CTRL      17'h00000
`define SACC_A_STAT      17'h00004
`define SACC_A_SEQ       17'h00008
`define SACC_A_PRM_LO    17'h00100
`define SACC_A_PRM_HI    17'h002FF
`define SACC_A_TWID_LO   17'h00800
`define SACC_A_TWID_HI   17'h00FFF
`define SACC_A_WIN_LO    17'h01000
`define SACC_A_WIN_HI    17'h01FFF
`define SACC_A_MEM_LO    17'h10000
`define SACC_BANK_WORDS  4096
`define SACC_NUM_SETS    16
`define SACC_SET_WORDS   8
`define SACC_FFT_LOG2    10
`define SACC_VEC_MAX     512
`define SACC_CFAR_MAX    8
`define SACC_RESP_OKAY   2'b00
`define SACC_RESP_DECERR 2'b11
`define SACC_OP_FFT      4'h0
`define SACC_OP_CA       4'h1
`define SACC_OP_SO       4'h2
`define SACC_OP_GO       4'h3
`define SACC_OP_VMUL     4'h4
`define SACC_OP_DOT      4'h5
`define SACC_OP_COPY     4'h6
`define SACC_POST_MAG    2'h1
`define SACC_POST_LOG    2'h2
`define SACC_TRIG_NONE   2'h0
`define SACC_TRIG_SW     2'h1
`define SACC_TRIG_EXT    2'h2
`define SACC_ST_IDLE     7'h01
`define SACC_ST_FETCH    7'h02
`define SACC_ST_TRIG     7'h04
`define SACC_ST_LOAD     7'h08
`define SACC_ST_FFT      7'h10
`define SACC_ST_STORE    7'h20
`define SACC_ST_NEXT     7'h40
`define SACC_CTRL_START  0
`define SACC_CTRL_TRIG   1
`define SACC_STAT_BUSY   0
`define SACC_STAT_DONE   1
`endif

/* File: rtl/sacc_engine.v */
// signal accelerator engine: sequencer, formatters, core unit, scratch memories and register slave
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "sacc_defines.vh"
// Summary of operation
// - radix-2 FFT, power-of-two length, 1024 max
// - butterflies carry 24-bit I and Q
// - optional halving after each stage, per stage
// - window, threshold zeroing, phase modulation removal
// - CA, smaller-of, greater-of detection, linear/log
// - element multiply and dot product, 512 max
// - magnitude and log-magnitude post-processing
// - one output sample per clock
// - input 16/32 real/complex to scaled 24-bit
// - output scaled to 32 or 16 bits
// - linear or transposed access, no extra cycles
// - sixteen parameter sets drive the engine
// - set selects operation and formatter setup
// - vector indices advance on each repeat
// - set runs repeat count plus one times
// - set may stall until its trigger
// - first set, set count, loop count registers
// - load, start, wait repeats, then advance
// - four scratch memories of 4096 words
module sacc_engine #(
  parameter BANK_WORDS = `SACC_BANK_WORDS,
  parameter FFT_LOG2   = `SACC_FFT_LOG2,
  parameter VEC_MAX    = `SACC_VEC_MAX
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [16:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [16:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        ext_trigger,
  output wire        seq_busy,
  output wire        seq_done
);
  localparam NFFT = 1 << FFT_LOG2;
  reg [31:0]        mem [0:4*BANK_WORDS-1];
  reg [31:0]        prm [0:`SACC_NUM_SETS*`SACC_SET_WORDS-1];
  reg [31:0]        twid [0:NFFT/2-1];
  reg [15:0]        win [0:NFFT-1];
  reg signed [23:0] wre [0:NFFT-1];
  reg signed [23:0] wim [0:NFFT-1];
  reg [31:0]        cfg [0:`SACC_SET_WORDS-1];
  reg [31:0]        seq_reg;
  reg [6:0]         state_reg;
  reg [3:0]         set_reg;
  reg [4:0]         sets_left_reg;
  reg [11:0]        loop_reg;
  reg [8:0]         rep_reg;
  reg [10:0]        idx_reg;
  reg [3:0]         stg_reg;
  reg               swtrig_reg, done_reg, done_pulse_reg, seq_busy_reg;
  reg signed [47:0] acc_re_reg, acc_im_reg;
  reg               awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  reg               aw_hold_reg, w_hold_reg;
  reg [1:0]         bresp_reg, rresp_reg;
  reg [16:0]        awaddr_reg;
  reg [31:0]        wdata_reg, rdata_reg;
  reg [3:0]         wstrb_reg;
  integer           k;
  integer           n;

  function [2:0] region;
    input [16:0] a;
    begin
      if (a == `SACC_A_CTRL) region = 3'h1;
      else if (a == `SACC_A_STAT) region = 3'h2;
      else if (a == `SACC_A_SEQ) region = 3'h3;
      else if (a >= `SACC_A_PRM_LO && a <= `SACC_A_PRM_HI) region = 3'h4;
      else if (a >= `SACC_A_TWID_LO && a <= `SACC_A_TWID_HI) region = 3'h5;
      else if (a >= `SACC_A_WIN_LO && a <= `SACC_A_WIN_HI) region = 3'h6;
      else if (a >= `SACC_A_MEM_LO) region = 3'h7;
      else region = 3'h0;
    end
  endfunction

  function [31:0] merge;
    input [31:0] old, nw;
    input [3:0]  strb;
    integer      b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1)
        if (strb[b]) merge[8*b +: 8] = nw[8*b +: 8];
    end
  endfunction

  // element address: stride gives transposed walks at full rate, inc moves per repeat
  function [13:0] xaddr;
    input [13:0] base;
    input [11:0] stride, inc;
    input [10:0] idx;
    input [8:0]  rep;
    reg [31:0]   t;
    begin
      t = base + idx * stride + rep * inc;
      xaddr = t[13:0];
    end
  endfunction

  function signed [23:0] in_conv;
    input [31:0] w;
    input        wide;
    input [3:0]  sh;
    reg [31:0]   t;
    begin
      if (wide) t = $signed(w) >>> sh;
      else t = {{16{w[15]}}, w[15:0]} << sh;
      in_conv = t[23:0];
    end
  endfunction

  function [31:0] out_conv;
    input signed [23:0] v;
    input               wide;
    input [3:0]         sh;
    reg [31:0]          t;
    begin
      if (wide) t = {{8{v[23]}}, v} << sh;
      else begin
        t = {{8{v[23]}}, v} >>> sh;
        t = {16'h0000, t[15:0]};
      end
      out_conv = t;
    end
  endfunction

  function [23:0] absv;
    input signed [23:0] v;
    begin
      absv = v[23] ? -v : v;
    end
  endfunction

  // max plus half min keeps the magnitude to a single adder
  function [23:0] mag;
    input signed [23:0] re, im;
    reg [23:0]          a, b;
    begin
      a = absv(re);
      b = absv(im);
      mag = (a > b) ? a + (b >> 1) : b + (a >> 1);
    end
  endfunction

  function [23:0] log2q;
    input [23:0] x;
    reg [4:0]    p;
    reg [23:0]   f;
    integer      i;
    begin
      p = 5'h00;
      for (i = 0; i < 24; i = i + 1)
        if (x[i]) p = i[4:0];
      f = (x << (5'd23 - p));
      log2q = {11'h000, p, f[22:15]};
    end
  endfunction

  function [9:0] brev;
    input [10:0] i;
    input [3:0]  l;
    integer      j;
    begin
      brev = 10'h000;
      for (j = 0; j < 10; j = j + 1)
        if (j < l) brev[l - 1 - j] = i[j];
    end
  endfunction

  // parameter set fields
  wire [3:0]  op       = cfg[0][3:0];
  wire [1:0]  trig_src = cfg[0][5:4];
  wire        cfar_log = cfg[0][6];
  wire        pmod_en  = cfg[0][7];
  wire        win_en   = cfg[0][8];
  wire        intf_en  = cfg[0][9];
  wire        in_cplx  = cfg[0][10];
  wire        in_wide  = cfg[0][11];
  wire        out_wide = cfg[0][12];
  wire        out_real = cfg[0][13];
  wire [3:0]  in_sh    = cfg[0][17:14];
  wire [3:0]  out_sh   = cfg[0][21:18];
  wire [1:0]  post     = cfg[0][23:22];
  wire [3:0]  flog     = cfg[1][14:11];
  wire [9:0]  smask    = cfg[1][24:15];
  wire        is_fft   = (op == `SACC_OP_FFT);
  wire [10:0] vlen     = (op == `SACC_OP_VMUL || op == `SACC_OP_DOT) && cfg[1][10:0] > VEC_MAX ?
                         VEC_MAX[10:0] : cfg[1][10:0];
  wire [10:0] nlen     = is_fft ? (11'h001 << flog) : vlen;
  wire [8:0]  rep_cnt  = cfg[3][8:0];
  wire [15:0] thr      = cfg[6][31:16];
  wire [3:0]  guard    = cfg[7][3:0];
  wire [1:0]  hw_log   = cfg[7][5:4];
  wire [7:0]  cscale   = cfg[7][15:8];
  wire        busy     = (state_reg != `SACC_ST_IDLE);

  // input formatter and pre-processing
  wire [13:0]        sa  = xaddr(cfg[2][13:0], cfg[4][11:0], cfg[4][23:12], idx_reg, rep_reg);
  wire [31:0]        w0  = mem[sa];
  wire [31:0]        w1  = mem[sa + 14'h0001];
  wire signed [23:0] ire = in_conv(w0, in_wide, in_sh);
  wire signed [23:0] iim = !in_cplx ? 24'sh000000 : in_wide ? in_conv(w1, 1'b1, in_sh) : in_conv(w0 >> 16, 1'b0, in_sh);
  wire               zap = intf_en && (absv(ire) > {thr, 8'h00} || absv(iim) > {thr, 8'h00});
  wire signed [40:0] wre_p = ire * $signed({1'b0, win[idx_reg[9:0]]});
  wire signed [40:0] wim_p = iim * $signed({1'b0, win[idx_reg[9:0]]});
  wire signed [23:0] pre  = zap ? 24'sh0 : win_en ? wre_p[38:15] : ire;
  wire signed [23:0] pim  = zap ? 24'sh0 : win_en ? wim_p[38:15] : iim;
  wire               flip = pmod_en && rep_reg[0];
  wire [9:0]         ld_i = is_fft ? brev(idx_reg, flog) : idx_reg[9:0];

  // radix-2 butterfly on two work-buffer entries
  wire [9:0]         half = 10'h001 << stg_reg;
  wire [9:0]         pos  = idx_reg[9:0] & (half - 10'h001);
  wire [9:0]         i0   = ((idx_reg[9:0] >> stg_reg) << (stg_reg + 4'h1)) | pos;
  wire [9:0]         i1   = i0 | half;
  wire [8:0]         tk   = pos[8:0] << (4'd9 - stg_reg);
  wire signed [15:0] tc   = twid[tk][31:16];
  wire signed [15:0] ts   = twid[tk][15:0];
  wire signed [40:0] tr_p = wre[i1] * tc + wim[i1] * ts;
  wire signed [40:0] tq_p = wim[i1] * tc - wre[i1] * ts;
  // signed views, so the sums sign-extend both operands
  wire signed [23:0] tw_r = tr_p[38:15];
  wire signed [23:0] tw_i = tq_p[38:15];
  wire signed [24:0] y0r  = wre[i0] + tw_r;
  wire signed [24:0] y0i  = wim[i0] + tw_i;
  wire signed [24:0] y1r  = wre[i0] - tw_r;
  wire signed [24:0] y1i  = wim[i0] - tw_i;
  wire               half_en = smask[stg_reg];

  // core result for the cell under the output formatter
  wire signed [23:0] xr = wre[idx_reg[9:0]];
  wire signed [23:0] xi = wim[idx_reg[9:0]];
  wire [13:0]        s2 = xaddr(cfg[6][13:0], cfg[4][11:0], cfg[4][23:12], idx_reg, rep_reg);
  wire signed [23:0] br = in_conv(mem[s2], 1'b0, in_sh);
  wire signed [23:0] bi = in_conv(mem[s2] >> 16, 1'b0, in_sh);
  wire signed [47:0] mr = xr * br - xi * bi;
  wire signed [47:0] mi = xr * bi + xi * br;
  wire signed [47:0] acc_r = acc_re_reg + mr;
  wire signed [47:0] acc_i = acc_im_reg + mi;
  reg  [27:0]        lsum, rsum;
  reg  [27:0]        avg;
  reg  [10:0]        ci;
  reg  signed [23:0] cr, cim;
  reg                det;
  always @* begin
    lsum = 28'h0;
    rsum = 28'h0;
    ci   = 11'h0;
    for (k = 1; k <= `SACC_CFAR_MAX; k = k + 1) begin
      if (k <= (1 << hw_log)) begin
        ci   = (idx_reg - {7'h00, guard} - k[10:0]) & (nlen - 11'h001);
        lsum = lsum + {4'h0, wre[ci[9:0]]};
        ci   = (idx_reg + {7'h00, guard} + k[10:0]) & (nlen - 11'h001);
        rsum = rsum + {4'h0, wre[ci[9:0]]};
      end
    end
    lsum = lsum >> hw_log;
    rsum = rsum >> hw_log;
    case (op)
      `SACC_OP_SO: avg = (lsum < rsum) ? lsum : rsum;
      `SACC_OP_GO: avg = (lsum > rsum) ? lsum : rsum;
      default:     avg = (lsum + rsum) >> 1;
    endcase
    if (cfar_log) det = {4'h0, xr} > avg + {20'h0, cscale};
    else det = {xr, 4'h0} > avg * cscale;
    case (op)
      `SACC_OP_CA, `SACC_OP_SO, `SACC_OP_GO: begin
        cr  = xr;
        cim = {23'h0, det};
      end
      `SACC_OP_VMUL: begin
        cr  = mr[38:15];
        cim = mi[38:15];
      end
      `SACC_OP_DOT: begin
        cr  = acc_r[38:15];
        cim = acc_i[38:15];
      end
      default: begin
        cr  = xr;
        cim = xi;
      end
    endcase
  end
  // post-processing precedes the output formatter
  wire signed [23:0] pr  = post == `SACC_POST_MAG ? mag(cr, cim) : post == `SACC_POST_LOG ? log2q(mag(cr, cim)) : cr;
  wire signed [23:0] pi2 = (post == `SACC_POST_MAG || post == `SACC_POST_LOG) ? 24'sh0 : cim;
  wire [31:0]        o_r = out_conv(pr, out_wide, out_sh);
  wire [31:0]        o_i = out_conv(pi2, out_wide, out_sh);
  wire               last = (idx_reg == nlen - 11'h001);
  wire [10:0]        didx = (op == `SACC_OP_DOT) ? 11'h000 : idx_reg;
  wire [13:0]        da   = xaddr(cfg[2][27:14], cfg[5][11:0], cfg[5][23:12], didx, rep_reg);
  wire               st   = (state_reg == `SACC_ST_STORE) && (op != `SACC_OP_DOT || last);
  wire               we0  = st;
  wire               we1  = st && out_wide && !out_real;
  wire [31:0]        o0   = out_wide ? o_r : out_real ? o_r : {o_i[15:0], o_r[15:0]};

  // register slave
  wire        wr_go = aw_hold_reg && w_hold_reg && !bvalid_reg;
  wire [2:0]  wreg  = region(awaddr_reg);
  wire [2:0]  rreg  = region(s_axi_araddr);
  wire [16:0] awo   = awaddr_reg - `SACC_A_PRM_LO;
  wire [16:0] awt   = awaddr_reg - `SACC_A_TWID_LO;
  wire [16:0] aww   = awaddr_reg - `SACC_A_WIN_LO;
  wire [16:0] awm   = awaddr_reg - `SACC_A_MEM_LO;
  wire [16:0] aro   = s_axi_araddr - `SACC_A_PRM_LO;
  wire [16:0] art   = s_axi_araddr - `SACC_A_TWID_LO;
  wire [16:0] arw   = s_axi_araddr - `SACC_A_WIN_LO;
  wire [16:0] ar_m  = s_axi_araddr - `SACC_A_MEM_LO;
  wire        start = wr_go && wreg == 3'h1 && wstrb_reg[0] && wdata_reg[`SACC_CTRL_START];
  wire        sw_tr = wr_go && wreg == 3'h1 && wstrb_reg[0] && wdata_reg[`SACC_CTRL_TRIG];
  wire        d_clr = wr_go && wreg == 3'h2 && wstrb_reg[0] && wdata_reg[`SACC_STAT_DONE];
  wire [31:0] win_m = merge({16'h0, win[aww[11:2]]}, wdata_reg, wstrb_reg);
  reg  [31:0] rmux;
  always @* begin
    case (rreg)
      3'h2:    rmux = {24'h0, set_reg, 2'h0, done_reg, busy};
      3'h3:    rmux = seq_reg;
      3'h4:    rmux = prm[aro[8:2]];
      3'h5:    rmux = twid[art[10:2]];
      3'h6:    rmux = {16'h0, win[arw[11:2]]};
      3'h7:    rmux = mem[ar_m[15:2]];
      default: rmux = 32'h0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `SACC_RESP_OKAY;
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= 17'h0;
      wdata_reg   <= 32'h0;
      wstrb_reg   <= 4'h0;
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= `SACC_RESP_OKAY;
    end else begin
      if (awready_reg && s_axi_awvalid) begin
        awready_reg <= 1'b0;
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (wready_reg && s_axi_wvalid) begin
        wready_reg <= 1'b0;
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= (wreg == 3'h0) ? `SACC_RESP_DECERR : `SACC_RESP_OKAY;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
      if (arready_reg && s_axi_arvalid) begin
        arready_reg <= 1'b0;
        rvalid_reg  <= 1'b1;
        rdata_reg   <= rmux;
        rresp_reg   <= (rreg == 3'h0) ? `SACC_RESP_DECERR : `SACC_RESP_OKAY;
      end
      if (rvalid_reg && s_axi_rready) begin
        rvalid_reg  <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  // storage: the host keeps tables still while busy
  always @(posedge aclk) begin
    if (wr_go && wreg == 3'h4) prm[awo[8:2]] <= merge(prm[awo[8:2]], wdata_reg, wstrb_reg);
    if (wr_go && wreg == 3'h5) twid[awt[10:2]] <= merge(twid[awt[10:2]], wdata_reg, wstrb_reg);
    if (wr_go && wreg == 3'h6) win[aww[11:2]] <= win_m[15:0];
    if (wr_go && wreg == 3'h7) mem[awm[15:2]] <= merge(mem[awm[15:2]], wdata_reg, wstrb_reg);
    if (we0) mem[da] <= o0;
    if (we1) mem[da + 14'h0001] <= o_i;
  end

  // work buffer: loaded once per repeat of each set, then updated in place stage by stage
  always @(posedge aclk) begin
    if (state_reg == `SACC_ST_LOAD) begin
      wre[ld_i] <= flip ? -pre : pre;
      wim[ld_i] <= flip ? -pim : pim;
    end
    if (state_reg == `SACC_ST_FFT) begin
      wre[i0] <= half_en ? y0r[24:1] : y0r[23:0];
      wim[i0] <= half_en ? y0i[24:1] : y0i[23:0];
      wre[i1] <= half_en ? y1r[24:1] : y1r[23:0];
      wim[i1] <= half_en ? y1i[24:1] : y1i[23:0];
    end
  end

  // sequencer
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_reg      <= `SACC_ST_IDLE;
      seq_reg        <= 32'h0;
      set_reg        <= 4'h0;
      sets_left_reg  <= 5'h00;
      loop_reg       <= 12'h000;
      rep_reg        <= 9'h000;
      idx_reg        <= 11'h000;
      stg_reg        <= 4'h0;
      swtrig_reg     <= 1'b0;
      done_reg       <= 1'b0;
      done_pulse_reg <= 1'b0;
      seq_busy_reg   <= 1'b0;
      acc_re_reg     <= 48'sh0;
      acc_im_reg     <= 48'sh0;
      for (n = 0; n < `SACC_SET_WORDS; n = n + 1)
        cfg[n] <= 32'h0;
    end else begin
      done_pulse_reg <= 1'b0;
      seq_busy_reg   <= busy;
      if (wr_go && wreg == 3'h3 && !busy) seq_reg <= merge(seq_reg, wdata_reg, wstrb_reg);
      if (sw_tr) swtrig_reg <= 1'b1;
      if (d_clr || start) done_reg <= 1'b0;
      case (state_reg)
        `SACC_ST_IDLE: if (start) begin
          set_reg       <= seq_reg[3:0];
          sets_left_reg <= {1'b0, seq_reg[7:4]} + 5'h01;
          loop_reg      <= seq_reg[19:8];
          state_reg     <= `SACC_ST_FETCH;
        end
        `SACC_ST_FETCH: begin
          for (n = 0; n < `SACC_SET_WORDS; n = n + 1)
            cfg[n] <= prm[{set_reg, 3'h0} + n[6:0]];
          rep_reg   <= 9'h000;
          state_reg <= `SACC_ST_TRIG;
        end
        `SACC_ST_TRIG: if (trig_src == `SACC_TRIG_NONE || (trig_src == `SACC_TRIG_SW && swtrig_reg) ||
                           (trig_src == `SACC_TRIG_EXT && ext_trigger)) begin
          if (trig_src == `SACC_TRIG_SW && !sw_tr) swtrig_reg <= 1'b0;
          idx_reg    <= 11'h000;
          acc_re_reg <= 48'sh0;
          acc_im_reg <= 48'sh0;
          state_reg  <= `SACC_ST_LOAD;
        end
        `SACC_ST_LOAD: begin
          idx_reg <= idx_reg + 11'h001;
          if (last) begin
            idx_reg   <= 11'h000;
            stg_reg   <= 4'h0;
            state_reg <= (is_fft && flog != 4'h0) ? `SACC_ST_FFT : `SACC_ST_STORE;
          end
        end
        `SACC_ST_FFT: begin
          idx_reg <= idx_reg + 11'h001;
          if (idx_reg == (nlen >> 1) - 11'h001) begin
            idx_reg <= 11'h000;
            stg_reg <= stg_reg + 4'h1;
            if (stg_reg == flog - 4'h1) state_reg <= `SACC_ST_STORE;
          end
        end
        `SACC_ST_STORE: begin
          idx_reg    <= idx_reg + 11'h001;
          acc_re_reg <= acc_r;
          acc_im_reg <= acc_i;
          if (last) begin
            if (rep_reg == rep_cnt) state_reg <= `SACC_ST_NEXT;
            else begin
              rep_reg   <= rep_reg + 9'h001;
              state_reg <= `SACC_ST_TRIG;
            end
          end
        end
        `SACC_ST_NEXT: begin
          state_reg <= `SACC_ST_FETCH;
          if (sets_left_reg == 5'h01) begin
            if (loop_reg == 12'h000) begin
              state_reg      <= `SACC_ST_IDLE;
              done_reg       <= 1'b1;
              done_pulse_reg <= 1'b1;
            end else begin
              loop_reg      <= loop_reg - 12'h001;
              set_reg       <= seq_reg[3:0];
              sets_left_reg <= {1'b0, seq_reg[7:4]} + 5'h01;
            end
          end else begin
            set_reg       <= set_reg + 4'h1;
            sets_left_reg <= sets_left_reg - 5'h01;
          end
        end
        default: state_reg <= `SACC_ST_IDLE;
      endcase
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign seq_busy      = seq_busy_reg;
  assign seq_done      = done_pulse_reg;
endmodule // sacc_engine

/* File: verif/sacc_engine_properties.sv */
// concurrent checks on the register bus and sequencer outputs
`timescale 1ns/1ps
module sacc_engine_properties (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        seq_busy,
  input wire        seq_done
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence rd_taken; s_axi_rvalid && s_axi_rready; endsequence
  sequence done_tail; !seq_done ##[0:1] !seq_busy; endsequence
  aw_drop_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("awready stayed high");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered");
  ar_back_a: assert property (rd_taken |-> ##[1:2] s_axi_arready)
    else $error("arready not back");
  dec_zero_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h3 |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  done_pulse_a: assert property (seq_done |=> done_tail)
    else $error("done not a pulse before idle");
  done_cause_a: assert property ($rose(seq_done) |-> $past(seq_busy))
    else $error("done without a run");
endmodule // sacc_engine_properties
bind sacc_engine sacc_engine_properties sacc_engine_properties_i (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .seq_busy, .seq_done);

/* File: verif/sacc_trig_model.sv */
// trigger source model; a late trigger shows whether a set really stalls
`timescale 1ns/1ps
module sacc_trig_model (
  input  wire       aclk,
  input  wire       trig_en,
  input  wire [7:0] dly,
  output logic      ext_trigger
);
  logic [7:0] cnt_reg;
  always @(posedge aclk) begin
    if (!trig_en) cnt_reg <= 8'h0;
    else if (cnt_reg != dly) cnt_reg <= cnt_reg + 8'h1;
    ext_trigger <= trig_en && (cnt_reg == dly);
  end
endmodule // sacc_trig_model

/* File: verif/tb_top.sv */
// self-checking bench for the signal accelerator engine
`timescale 1ns/1ps
`include "sacc_defines.vh"
module tb_top;
  logic aclk = 1'h0, aresetn = 1'h0, trig_en = 1'h0, ext_trigger;
  logic [16:0] s_axi_awaddr = 17'h0, s_axi_araddr = 17'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, seq_busy, seq_done;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [65:0] rq[$];
  logic [1:0] bq[$];
  logic [31:0] src[8];
  logic [31:0] pw[8] = '{32'h426, 32'h4, 32'h4000000, 32'h1, 32'h4001, 32'h4001, 32'h0, 32'h0};
  logic [3:0] fset;
  int n_errors = 0, comparisons = 0, n_done = 0;
  always #2 aclk = ~aclk;
  sacc_engine sacc_engine_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_trigger,
    .seq_busy, .seq_done);
  sacc_trig_model sacc_trig_model_i (.aclk, .trig_en, .dly(8'hFF), .ext_trigger);
  task automatic cmp_word(input logic [31:0] g, e, m);
    comparisons++;
    if ((g & m) !== (e & m)) begin
      n_errors++;
      $display("ERROR %0t word %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_resp(input logic [1:0] g, e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %0t response %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [16:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    bq.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask
  task automatic rd(input logic [16:0] a, input logic [31:0] e, m, input logic [1:0] r);
    @(posedge aclk);
    rq.push_back({e, m, r});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
  endtask
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      cmp_word(s_axi_rdata, rq[0][65:34], rq[0][33:2]);
      cmp_resp(s_axi_rresp, rq.pop_front());
    end
    if (s_axi_bvalid && s_axi_bready) cmp_resp(s_axi_bresp, bq.pop_front());
    if (seq_done) n_done++;
  end
  task automatic complete_run;
    $display("counts: %0d errors, %0d comparisons", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #40000;
    n_errors++;
    $display("ERROR %0t watchdog expired", $time);
    complete_run;
  end
  initial begin
    void'($urandom(32'hA0DECAA5));
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    rd(`SACC_A_STAT, 32'h0, 32'h3, `SACC_RESP_OKAY);
    rd(17'h0000C, 32'h0, 32'hFFFFFFFF, `SACC_RESP_DECERR);
    wr(17'h0000C, 32'h1, `SACC_RESP_DECERR);
    fset = $urandom;
    wr(`SACC_A_SEQ, {24'h0, 4'h0, fset}, `SACC_RESP_OKAY);
    rd(`SACC_A_SEQ, {24'h0, 4'h0, fset}, 32'hFFFFF, `SACC_RESP_OKAY);
    $display("test registers finished");
    for (int i = 0; i < 8; i++) begin
      src[i] = $urandom & 32'h3FFF3FFF;
      wr(17'h10000 + 17'(i * 4), src[i], `SACC_RESP_OKAY);
      wr(17'h14000 + 17'(i * 4), 32'hFFFFFFFF, `SACC_RESP_OKAY);
      wr(`SACC_A_PRM_LO + 17'(fset * 32 + i * 4), pw[i], `SACC_RESP_OKAY);
    end
    $display("test programming finished");
    trig_en <= 1'h1;
    wr(`SACC_A_CTRL, 32'h1, `SACC_RESP_OKAY);
    repeat (20) @(posedge aclk);
    rd(`SACC_A_STAT, {24'h0, fset, 4'h1}, 32'hF3, `SACC_RESP_OKAY);
    while (seq_busy) @(posedge aclk);
    trig_en <= 1'h0;
    rd(`SACC_A_STAT, 32'h2, 32'h3, `SACC_RESP_OKAY);
    cmp_word(32'(n_done), 32'h1, 32'hFFFFFFFF);
    for (int i = 0; i < 8; i++) rd(17'h14000 + 17'(i * 4), src[i], 32'hFFFFFFFF, `SACC_RESP_OKAY);
    wr(`SACC_A_STAT, 32'h2, `SACC_RESP_OKAY);
    rd(`SACC_A_STAT, 32'h0, 32'h3, `SACC_RESP_OKAY);
    $display("test sequence finished");
    complete_run;
  end
endmodule // tb_top
